// File: design/ncosc_control.v
// Purpose: oscillator control registers and sync trigger selection
// Assumes: byte register port on clk_i; sysref_i from another domain
// Notes: oscillator arithmetic lives outside; this emits controls and events
// Operation
// - bit 7 selects fast-port oscillator controls
// - bit 2 shares channel 0 reference counter
// - bit 1 selects synthesis once datapath enabled
// - bit 0 enables mixing with oscillator
// - source field picks sync event trigger
// - code 0: sync bit fires immediately
// - code 1: fire once at next sysref
// - code 2: fire every sysref while bit high
// - code 3: four lows then four highs
// - fire on fourth high marker sample
// - fast mode events use fast-port values
// - fast code 0: fire on chip-select rise
// - fast code 3: await marker after chip-select
// - zero sample lsb while awaiting fast-mode marker
// - sync bit rising write starts events outside fast mode; fast mode starts on chip-select rise
// - reset masked accumulators on each event
`timescale 1ns/1ps
`include "ncosc_regs.vh"
module ncosc_control #(
	parameter NUM_OSC = 4
)(
	// clock and reset
	input wire clk_i,
	input wire reset_i,
	// register port
	input wire reg_wr_i,
	input wire reg_rd_i,
	input wire [9:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	output reg [7:0] reg_rdata_o,
	// datapath state
	input wire datapath_enable_i,
	input wire sysref_i,
	// upconverter zero in-phase sample lsb
	input wire sample_valid_i,
	input wire sample_lsb_i,
	output wire sample_lsb_o,
	// fast reconfiguration port
	input wire fast_chip_select_i,
	input wire fast_sync_flag_i,
	input wire [NUM_OSC-1:0] fast_accum_reset_mask_i,
	// oscillator controls
	output wire fast_reconfig_enable_o,
	output wire self_coherent_select_o,
	output wire synth_mode_enable_o,
	output wire mixer_enable_o,
	output wire [NUM_OSC-1:0] phase_continuous_mask_o,
	output wire [NUM_OSC-1:0] reseed_on_change_o,
	// sync events
	output reg sync_event_o,
	output reg apply_fast_values_o,
	output reg [NUM_OSC-1:0] accum_reset_o,
	output wire marker_wait_o
);
	reg [7:0] oscillator_control;
	reg [7:0] phase_continuous_mask;
	reg [7:0] sync_trigger_config;
	reg [7:0] accumulator_reset_mask;
	reg [7:0] sw_sync;
	reg sysref_meta;
	reg sysref_sync;
	reg sysref_prev;
	reg cs_meta;
	reg cs_sync;
	reg cs_prev;
	reg sysref_pending;
	reg fast_wait;
	reg next_sync;
	reg [7:0] next_rdata;
	wire fast_on;
	wire [1:0] src;
	wire sysref_rise;
	wire cs_rise;
	wire sw_rise_wr;
	wire marker_arm;
	wire marker_hit;
	wire fast_marker_start;
	assign fast_on = oscillator_control[`NCOSC_BIT_FAST];
	assign src = sync_trigger_config[`NCOSC_SRC_HI:`NCOSC_SRC_LO];
	assign sysref_rise = sysref_sync && !sysref_prev;
	assign cs_rise = cs_sync && !cs_prev;
	// only a write of 1 over a held 0 starts events
	assign sw_rise_wr = reg_wr_i && (reg_addr_i == `NCOSC_ADDR_SWSYNC)
		&& reg_wdata_i[`NCOSC_BIT_SWSYNC] && !sw_sync[`NCOSC_BIT_SWSYNC];
	assign fast_marker_start = fast_on && (src == `NCOSC_SRC_MARKER)
		&& cs_rise && fast_sync_flag_i;
	assign marker_arm = fast_on ? fast_wait
		: (src == `NCOSC_SRC_MARKER) && sw_sync[`NCOSC_BIT_SWSYNC];
	assign marker_wait_o = fast_on && fast_wait;
	// data lsb masked until the marker completes, in fast mode only
	assign sample_lsb_o = sample_lsb_i && !marker_wait_o;
	assign fast_reconfig_enable_o = oscillator_control[`NCOSC_BIT_FAST];
	assign self_coherent_select_o = oscillator_control[`NCOSC_BIT_SC];
	// synthesis mode takes effect only with the datapath running
	assign synth_mode_enable_o = oscillator_control[`NCOSC_BIT_SYNTH]
		&& datapath_enable_i;
	assign mixer_enable_o = oscillator_control[`NCOSC_BIT_MIX];
	assign phase_continuous_mask_o = phase_continuous_mask[NUM_OSC-1:0];
	assign reseed_on_change_o = ~phase_continuous_mask[NUM_OSC-1:0];
	ncosc_marker #(
		.MARK_LEN(`NCOSC_MARK_LEN)
	) u_marker (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.arm_i(marker_arm),
		.sample_valid_i(sample_valid_i),
		.lsb_i(sample_lsb_i),
		.hit_o(marker_hit)
	);
	// register writes; rule-1 and rule-18 timing is left to software
	always @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			oscillator_control <= `NCOSC_RST_CTRL;
			phase_continuous_mask <= `NCOSC_RST_CONT;
			sync_trigger_config <= `NCOSC_RST_SYNC;
			accumulator_reset_mask <= `NCOSC_RST_AR;
			sw_sync <= `NCOSC_RST_SWSYNC;
		end
		else if (reg_wr_i)
		begin
			case (reg_addr_i)
				`NCOSC_ADDR_CTRL: oscillator_control <= reg_wdata_i;
				`NCOSC_ADDR_CONT: phase_continuous_mask <= reg_wdata_i;
				`NCOSC_ADDR_SYNC: sync_trigger_config <= reg_wdata_i;
				`NCOSC_ADDR_AR: accumulator_reset_mask <= reg_wdata_i;
				`NCOSC_ADDR_SWSYNC: sw_sync <= reg_wdata_i;
				default: sw_sync <= sw_sync;
			endcase
		end
	end
	// sysref and chip select come from pins: two flops first
	always @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			sysref_meta <= 1'b0;
			sysref_sync <= 1'b0;
			sysref_prev <= 1'b0;
			cs_meta <= 1'b1;
			cs_sync <= 1'b1;
			cs_prev <= 1'b1;
		end
		else
		begin
			sysref_meta <= sysref_i;
			sysref_sync <= sysref_meta;
			sysref_prev <= sysref_sync;
			cs_meta <= fast_chip_select_i;
			cs_sync <= cs_meta;
			cs_prev <= cs_sync;
		end
	end
	// which trigger fires this cycle
	always @*
	begin
		next_sync = 1'b0;
		if (fast_on)
		begin
			case (src)
				`NCOSC_SRC_NOW: next_sync = cs_rise && fast_sync_flag_i;
				`NCOSC_SRC_MARKER: next_sync = marker_hit;
				default: next_sync = 1'b0;
			endcase
		end
		else
		begin
			case (src)
				`NCOSC_SRC_NOW: next_sync = sw_rise_wr;
				`NCOSC_SRC_SYSREF_ONCE: next_sync = sysref_pending && sysref_rise;
				`NCOSC_SRC_SYSREF_ALL: next_sync = sw_sync[`NCOSC_BIT_SWSYNC] && sysref_rise;
				`NCOSC_SRC_MARKER: next_sync = marker_hit;
				default: next_sync = 1'b0;
			endcase
		end
	end
	always @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			sysref_pending <= 1'b0;
			fast_wait <= 1'b0;
		end
		else
		begin
			// a fresh arm in the firing cycle wins over the clear
			if (!fast_on && src == `NCOSC_SRC_SYSREF_ONCE && sw_rise_wr)
				sysref_pending <= 1'b1;
			else if (sysref_rise || fast_on || src != `NCOSC_SRC_SYSREF_ONCE)
				sysref_pending <= 1'b0;
			if (fast_marker_start)
				fast_wait <= 1'b1;
			else if (marker_hit || !fast_on)
				fast_wait <= 1'b0;
		end
	end
	// one-cycle events, all in the same cycle
	always @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			sync_event_o <= 1'b0;
			apply_fast_values_o <= 1'b0;
			accum_reset_o <= {NUM_OSC{1'b0}};
		end
		else
		begin
			sync_event_o <= next_sync;
			apply_fast_values_o <= next_sync && fast_on;
			if (!next_sync)
				accum_reset_o <= {NUM_OSC{1'b0}};
			else if (fast_on)
				accum_reset_o <= fast_accum_reset_mask_i;
			else
				accum_reset_o <= accumulator_reset_mask[NUM_OSC-1:0];
		end
	end
	// read back; unmapped reads zero, reserved bits as stored
	always @*
	begin
		next_rdata = 8'h00;
		if (reg_rd_i)
		begin
			case (reg_addr_i)
				`NCOSC_ADDR_CTRL: next_rdata = oscillator_control;
				`NCOSC_ADDR_CONT: next_rdata = phase_continuous_mask;
				`NCOSC_ADDR_SYNC: next_rdata = sync_trigger_config;
				`NCOSC_ADDR_AR: next_rdata = accumulator_reset_mask;
				`NCOSC_ADDR_SWSYNC: next_rdata = sw_sync;
				default: next_rdata = 8'h00;
			endcase
		end
	end
	// registered so read data never glitches; costs one cycle of latency
	always @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			reg_rdata_o <= 8'h00;
		else
			reg_rdata_o <= next_rdata;
	end
endmodule // ncosc_control

// File: design/ncosc_regs.vh
// Purpose: constants for the oscillator sync control block
// Assumes: byte-wide register port, offsets as printed
// Notes: included by the design files only
`ifndef NCOSC_REGS_VH
`define NCOSC_REGS_VH
`define NCOSC_ADDR_CTRL 10'h300
`define NCOSC_ADDR_CONT 10'h301
`define NCOSC_ADDR_SYNC 10'h302
`define NCOSC_ADDR_AR 10'h303
`define NCOSC_ADDR_SWSYNC 10'h304
`define NCOSC_RST_CTRL 8'h00
`define NCOSC_RST_CONT 8'h00
`define NCOSC_RST_SYNC 8'h00
`define NCOSC_RST_AR 8'h0f
`define NCOSC_RST_SWSYNC 8'h00
`define NCOSC_BIT_FAST 7
`define NCOSC_BIT_SC 2
`define NCOSC_BIT_SYNTH 1
`define NCOSC_BIT_MIX 0
`define NCOSC_BIT_SWSYNC 0
`define NCOSC_SRC_HI 1
`define NCOSC_SRC_LO 0
`define NCOSC_MASK_CTRL 8'h87
`define NCOSC_MASK_LOW4 8'h0f
`define NCOSC_MASK_SRC 8'h03
`define NCOSC_MASK_BIT0 8'h01
`define NCOSC_SRC_NOW 2'h0
`define NCOSC_SRC_SYSREF_ONCE 2'h1
`define NCOSC_SRC_SYSREF_ALL 2'h2
`define NCOSC_SRC_MARKER 2'h3
`define NCOSC_MARK_LEN 4
`endif

// File: design/ncosc_marker.v
// Purpose: lsb marker detector, four or more lows then four highs
// Assumes: one sample per clock when sample_valid_i is high
// Notes: count of lows saturates at the required length
`timescale 1ns/1ps
`include "ncosc_regs.vh"
module ncosc_marker #(
	parameter MARK_LEN = `NCOSC_MARK_LEN
)(
	// clock and reset
	input wire clk_i,
	input wire reset_i,
	// control
	input wire arm_i,
	// samples
	input wire sample_valid_i,
	input wire lsb_i,
	// result
	output wire hit_o
);
	reg [3:0] low_count;
	reg [3:0] high_count;
	wire low_ok;
	assign low_ok = (low_count >= MARK_LEN[3:0]);
	// fourth high after enough lows, same cycle as that sample
	assign hit_o = arm_i && sample_valid_i && lsb_i && low_ok
		&& (high_count == MARK_LEN[3:0] - 4'h1);
	always @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			low_count <= 4'h0;
			high_count <= 4'h0;
		end
		else if (!arm_i || hit_o)
		begin
			low_count <= 4'h0;
			high_count <= 4'h0;
		end
		else if (sample_valid_i)
		begin
			if (!lsb_i)
			begin
				if (high_count != 4'h0)
					low_count <= 4'h1;
				else if (!low_ok)
					low_count <= low_count + 4'h1;
				high_count <= 4'h0;
			end
			else if (!low_ok)
			begin
				// early high restarts the low run
				low_count <= 4'h0;
				high_count <= 4'h0;
			end
			else
				high_count <= high_count + 4'h1;
		end
	end
endmodule // ncosc_marker

// File: verif/ncosc_props.sv
// Purpose: port assertions for sync_trigger_config_control
// Assumes: one clock, async active high reset
// Notes: shadows mirror register writes
`timescale 1ns/1ps
module ncosc_props #(
	parameter NUM_OSC = 4
)(
	// clock, reset, register port
	input logic clk_i,
	input logic reset_i,
	input logic reg_wr_i,
	input logic [9:0] reg_addr_i,
	input logic [7:0] reg_wdata_i,
	input logic datapath_enable_i,
	// watched outputs
	input logic sample_lsb_o,
	input logic fast_reconfig_enable_o,
	input logic self_coherent_select_o,
	input logic synth_mode_enable_o,
	input logic mixer_enable_o,
	input logic [NUM_OSC-1:0] phase_continuous_mask_o,
	input logic [NUM_OSC-1:0] reseed_on_change_o,
	input logic sync_event_o,
	input logic apply_fast_values_o,
	input logic [NUM_OSC-1:0] accum_reset_o,
	input logic marker_wait_o
);
	logic [7:0] ctl;
	logic [1:0] src;
	logic [NUM_OSC-1:0] ar;
	logic [NUM_OSC-1:0] cont;
	logic sw;
	always @(posedge clk_i or posedge reset_i)
		if (reset_i)
		begin
			ctl <= 8'h00;
			src <= 2'h0;
			ar <= {NUM_OSC{1'b1}};
			cont <= {NUM_OSC{1'b0}};
			sw <= 1'b0;
		end
		else if (reg_wr_i)
		begin
			if (reg_addr_i == 10'h300) ctl <= reg_wdata_i;
			if (reg_addr_i == 10'h301) cont <= reg_wdata_i[NUM_OSC-1:0];
			if (reg_addr_i == 10'h302) src <= reg_wdata_i[1:0];
			if (reg_addr_i == 10'h303) ar <= reg_wdata_i[NUM_OSC-1:0];
			if (reg_addr_i == 10'h304) sw <= reg_wdata_i[0];
		end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// only a 0 to 1 write counts, so shadow sw matters
	sequence s_sw_rise;
		reg_wr_i && reg_addr_i == 10'h304 && reg_wdata_i[0] && !sw && src == 2'h0 && !ctl[7];
	endsequence
	sequence s_fire;
		sync_event_o && accum_reset_o == ar;
	endsequence
	property p_now; s_sw_rise |=> s_fire; endproperty
	a_now: assert property (p_now) else $error("no event after sync write");
	property p_ctl;
		mixer_enable_o == ctl[0] && self_coherent_select_o == ctl[2] && fast_reconfig_enable_o == ctl[7];
	endproperty
	a_ctl: assert property (p_ctl) else $error("control bits wrong");
	property p_synth; synth_mode_enable_o == (ctl[1] && datapath_enable_i); endproperty
	a_synth: assert property (p_synth) else $error("synth mode wrong");
	property p_cont; phase_continuous_mask_o == cont && reseed_on_change_o == ~cont; endproperty
	a_cont: assert property (p_cont) else $error("reseed mask wrong");
	property p_pulse; sync_event_o |=> !sync_event_o; endproperty
	a_pulse: assert property (p_pulse) else $error("event too long");
	property p_ar; accum_reset_o != {NUM_OSC{1'b0}} |-> sync_event_o; endproperty
	a_ar: assert property (p_ar) else $error("reset outside event");
	property p_fast; apply_fast_values_o == (sync_event_o && fast_reconfig_enable_o); endproperty
	a_fast: assert property (p_fast) else $error("fast apply wrong");
	property p_lsbz; marker_wait_o |-> !sample_lsb_o; endproperty
	a_lsbz: assert property (p_lsbz) else $error("lsb not zeroed");
	property p_wait; marker_wait_o |-> fast_reconfig_enable_o && src == 2'h3; endproperty
	a_wait: assert property (p_wait) else $error("marker wait wrong");
endmodule // ncosc_props
bind ncosc_control ncosc_props #(.NUM_OSC(NUM_OSC)) u_props (.clk_i, .reset_i, .reg_wr_i,
	.reg_addr_i, .reg_wdata_i, .datapath_enable_i, .sample_lsb_o, .fast_reconfig_enable_o,
	.self_coherent_select_o, .synth_mode_enable_o, .mixer_enable_o, .phase_continuous_mask_o,
	.reseed_on_change_o, .sync_event_o, .apply_fast_values_o, .accum_reset_o, .marker_wait_o);

// File: verif/ncosc_host.sv
// Purpose: far side model, samples, sysref and fast chip select
// Assumes: drives on falling edges
// Notes: calls come from the bench
`timescale 1ns/1ps
module ncosc_host (
	// clock
	input logic clk_i,
	// driven lines
	output logic sample_valid_o,
	output logic sample_lsb_o,
	output logic cs_o,
	output logic sysref_o
);
	initial
	begin
		sample_valid_o = 1'b0;
		sample_lsb_o = 1'b0;
		cs_o = 1'b1;
		sysref_o = 1'b0;
	end
	task samp(input int n, input logic v);
		repeat (n)
		begin
			@(negedge clk_i);
			sample_valid_o = 1'b1;
			sample_lsb_o = v;
		end
	endtask
	// stale lsb inverted so nothing leans on it
	task idle;
		@(negedge clk_i);
		sample_valid_o = 1'b0;
		sample_lsb_o = ~sample_lsb_o;
	endtask
	// chip select back high before any source change
	task cs_pulse;
		@(negedge clk_i);
		cs_o = 1'b0;
		repeat (4) @(negedge clk_i);
		cs_o = 1'b1;
		repeat (8) @(negedge clk_i);
	endtask
	task sref;
		@(negedge clk_i);
		sysref_o = 1'b1;
		repeat (3) @(negedge clk_i);
		sysref_o = 1'b0;
		repeat (8) @(negedge clk_i);
	endtask
endmodule // ncosc_host

// File: verif/test_sync_trigger_config_control.sv
// Purpose: register and sync trigger tests
// Assumes: byte port, events counted at posedge
// Notes: fast mask held at 3
`timescale 1ns/1ps
module test_sync_trigger_config_control;
	logic clk_i = 0, reset_i = 1, wr = 0, rd = 0, dp = 0, flag = 0;
	logic [9:0] ad = 0;
	logic [7:0] wd = 0, rdat, n_ev = 0, l_ar;
	logic fe, sc, sy, mx, v, lsb, cs, sr, lo, ev, ap, mw, l_ap;
	logic [3:0] pc, rs, ar;
	int num_errors = 0, samples_checked = 0;
	ncosc_control u_dut (.clk_i, .reset_i, .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(ad),
		.reg_wdata_i(wd), .reg_rdata_o(rdat), .datapath_enable_i(dp), .sysref_i(sr),
		.sample_valid_i(v), .sample_lsb_i(lsb), .sample_lsb_o(lo), .fast_chip_select_i(cs),
		.fast_sync_flag_i(flag), .fast_accum_reset_mask_i(4'h3), .fast_reconfig_enable_o(fe),
		.self_coherent_select_o(sc), .synth_mode_enable_o(sy), .mixer_enable_o(mx),
		.phase_continuous_mask_o(pc), .reseed_on_change_o(rs), .sync_event_o(ev),
		.apply_fast_values_o(ap), .accum_reset_o(ar), .marker_wait_o(mw));
	ncosc_host u_host (.clk_i, .sample_valid_o(v), .sample_lsb_o(lsb), .cs_o(cs), .sysref_o(sr));
	initial forever #12.5 clk_i = ~clk_i;
	always @(posedge clk_i)
		if (ev)
		begin
			n_ev <= n_ev + 8'h01;
			l_ar <= {4'h0, ar};
			l_ap <= ap;
		end
	task chk(input string nm, input logic [15:0] s, e);
		samples_checked++;
		if (s !== e)
		begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task w(input logic [9:0] a, input logic [7:0] d);
		@(negedge clk_i);
		{wr, ad, wd} = {1'b1, a, d};
		@(negedge clk_i);
		wr = 0;
	endtask
	task r(input logic [9:0] a, input logic [7:0] e);
		@(negedge clk_i);
		{rd, ad} = {1'b1, a};
		@(negedge clk_i);
		chk("rdata", rdat, e);
		rd = 0;
	endtask
	task report_and_stop;
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		#100us;
		num_errors++;
		report_and_stop;
	end
	initial
	begin
		repeat (20) @(negedge clk_i);
		reset_i = 0;
		for (int i = 0; i < 5; i++) r(10'h300 + i, i == 3 ? 8'h0f : 8'h00);
		r(10'h305, 8'h00);
		w(10'h300, 8'h87);
		r(10'h300, 8'h87);
		chk("ctl", {fe, sc, sy, mx}, 4'b1101);
		dp = 1;
		#1 chk("synth", sy, 1);
		dp = 0;
		w(10'h300, 8'h00);
		w(10'h301, 8'hf5);
		r(10'h301, 8'hf5);
		chk("mask", {pc, rs}, 8'h5a);
		w(10'h304, 8'h01);
		w(10'h304, 8'h01);
		r(10'h304, 8'h01);
		chk("src0", {n_ev, l_ar}, 16'h010f);
		w(10'h304, 8'h00);
		w(10'h303, 8'h05);
		w(10'h302, 8'h01);
		w(10'h304, 8'h01);
		chk("src1 armed", n_ev, 1);
		repeat (2) u_host.sref;
		chk("src1", {n_ev, l_ar}, 16'h0205);
		w(10'h304, 8'h00);
		w(10'h302, 8'h02);
		w(10'h304, 8'h01);
		repeat (2) u_host.sref;
		w(10'h304, 8'h00);
		u_host.sref;
		chk("src2", n_ev, 4);
		w(10'h302, 8'h03);
		w(10'h304, 8'h01);
		u_host.samp(3, 0);
		u_host.samp(4, 1);
		u_host.samp(4, 0);
		u_host.samp(3, 1);
		chk("early", n_ev, 4);
		u_host.samp(1, 1);
		@(negedge clk_i);
		chk("marker", ev, 1);
		u_host.idle;
		w(10'h304, 8'h00);
		w(10'h302, 8'h00);
		w(10'h300, 8'h80);
		flag = 1;
		u_host.cs_pulse;
		chk("fast0", {n_ev, l_ar[3:0], l_ap}, 13'h0c7);
		flag = 0;
		u_host.cs_pulse;
		flag = 1;
		for (int c = 1; c < 3; c++)
		begin
			w(10'h302, c[7:0]);
			u_host.cs_pulse;
		end
		chk("reserved", n_ev, 6);
		w(10'h302, 8'h03);
		u_host.cs_pulse;
		chk("wait", mw, 1);
		u_host.samp(4, 0);
		u_host.samp(3, 1);
		#1 chk("lsb zero", lo, 0);
		u_host.samp(1, 1);
		@(negedge clk_i);
		chk("fast3", {mw, lo, ev}, 3'b011);
		report_and_stop;
	end
endmodule // test_sync_trigger_config_control
